// [verilog/alr_pkg.sv]
/*
  Shared constants and types for the ambient light readout block:
  serial slave address, register offsets, field positions, reset values,
  gain codes, timing and the serial engine's state encoding.
  Assumes a single 50 MHz core clock.
*/
package alr_pkg;

  // ----------------------------------------------------------------
  // serial slave and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR    = 7'h39;
  localparam logic [7:0] REG_MODE      = 8'h41;  // operating_mode_and_timing
  localparam logic [7:0] REG_GAIN      = 8'h42;  // gain_and_sensor_control
  localparam logic [7:0] REG_VIS_LO    = 8'h46;
  localparam logic [7:0] REG_VIS_HI    = 8'h47;
  localparam logic [7:0] REG_IR_LO     = 8'h48;
  localparam logic [7:0] REG_IR_HI     = 8'h49;
  localparam logic [7:0] REG_STATUS    = 8'h4a;
  localparam logic [7:0] REG_UPPER_LO  = 8'h4b;
  localparam logic [7:0] REG_UPPER_HI  = 8'h4c;
  localparam logic [7:0] REG_LOWER_LO  = 8'h4d;
  localparam logic [7:0] REG_LOWER_HI  = 8'h4e;

  // field positions
  localparam int MODE_MEAS_EN_BIT  = 0;
  localparam int MODE_TIME_SEL_BIT = 1;
  localparam int GAIN_SEL_LSB      = 0;
  localparam int GAIN_INT_EN_BIT   = 2;
  localparam int STATUS_INT_BIT    = 0;

  // reset values
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [7:0]  GAIN_RESET  = 8'h00;
  localparam logic [15:0] UPPER_RESET = 16'hffff;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int T_SHORT_MS     = 100;
  localparam int T_LONG_MS      = 400;
  localparam int T_SHORT_CYC    = (CLK_HZ / 1000) * T_SHORT_MS;
  localparam int T_LONG_CYC     = (CLK_HZ / 1000) * T_LONG_MS;

  // serial engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ADDR  = 5'h02,
    ST_PTR   = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } alr_st_t;

  // gain code to per-pulse count step: 1, 2, 64, 128
  function automatic logic [7:0] gain_step(input logic [1:0] sel);
    case (sel)
      2'h0:    gain_step = 8'h01;
      2'h1:    gain_step = 8'h02;
      2'h2:    gain_step = 8'h40;
      default: gain_step = 8'h80;
    endcase
  endfunction : gain_step

  // saturating add keeps counts at full scale instead of wrapping
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [7:0] g);
    logic [16:0] s;
    s = {1'b0, a} + {9'h000, g};
    sat_add = s[16] ? COUNT_MAX : s[15:0];
  endfunction : sat_add

endpackage : alr_pkg

// [verilog/alr_reg_if.sv]
/*
  Byte register access between the serial slave engine and the
  register file. Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
interface alr_reg_if;
  logic       wr_stb;  // one-cycle write pulse
  logic [7:0] addr;    // register pointer
  logic [7:0] wdata;
  logic [7:0] rdata;   // read data for addr, combinational

  modport slave (output wr_stb, output addr, output wdata, input rdata);
  modport regs  (input wr_stb, input addr, input wdata, output rdata);
endinterface : alr_reg_if

// [verilog/alr_i2c_slave.sv]
/*
  Two-wire serial slave engine: address match, register pointer,
  auto-incrementing burst writes and reads.
  Assumes clock and data lines already synchronous to the core clock and
  a line period of many core clocks.
*/
`timescale 1ns/1ps
module alr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = alr_pkg::SLAVE_ADDR
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe,
  alr_reg_if.slave  regs
);

  // ----------------------------------------------------------------
  // line edge and condition detect
  // ----------------------------------------------------------------
  logic              scl_q_ff, sda_q_ff;
  alr_pkg::alr_st_t  state_ff, nxt_state;
  logic [3:0]        bit_cnt_ff, nxt_bit_cnt;
  logic [7:0]        shift_ff, nxt_shift;
  logic [7:0]        ptr_ff, nxt_ptr;
  logic              sda_oe_ff, nxt_sda_oe;
  logic              wr_pulse;

  wire start_cond = i_scl & scl_q_ff & sda_q_ff & ~i_sda;
  wire stop_cond  = i_scl & scl_q_ff & ~sda_q_ff & i_sda;
  wire scl_rise   = i_scl & ~scl_q_ff;
  wire scl_fall   = ~i_scl & scl_q_ff;
  wire addr_hit   = shift_ff[7:1] == DEV_ADDR;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  // bit counter runs 0..9: eight data bits, the ack bit, then wrap
  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_ptr     = ptr_ff;
    nxt_sda_oe  = sda_oe_ff;
    wr_pulse    = 1'b0;
    if (start_cond) begin
      nxt_state   = alr_pkg::ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe  = 1'b0;
    end else if (stop_cond || state_ff == alr_pkg::ST_IDLE) begin
      nxt_state   = alr_pkg::ST_IDLE;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe  = 1'b0;
    end else if (scl_rise) begin
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
      if (bit_cnt_ff < 4'h8 && state_ff != alr_pkg::ST_RDATA)
        nxt_shift = {shift_ff[6:0], i_sda};
      // a nack from the host ends the read burst
      if (bit_cnt_ff == 4'h8 && state_ff == alr_pkg::ST_RDATA && i_sda)
        nxt_state = alr_pkg::ST_IDLE;
    end else if (scl_fall) begin
      if (bit_cnt_ff == 4'h8) begin
        nxt_sda_oe = state_ff != alr_pkg::ST_RDATA;
        case (state_ff)
          alr_pkg::ST_ADDR: begin
            if (!addr_hit) begin
              nxt_state  = alr_pkg::ST_IDLE;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_state = shift_ff[0] ? alr_pkg::ST_RDATA : alr_pkg::ST_PTR;
            end
          end
          alr_pkg::ST_PTR: begin
            nxt_ptr   = shift_ff;
            nxt_state = alr_pkg::ST_WDATA;
          end
          alr_pkg::ST_WDATA: begin
            wr_pulse = 1'b1;  // write strobe for every data byte, to whichever register the pointer names
            nxt_ptr  = ptr_ff + 8'h01;
          end
          default: ;
        endcase
      end else if (bit_cnt_ff == 4'h9) begin
        nxt_bit_cnt = 4'h0;
        nxt_sda_oe  = 1'b0;
        if (state_ff == alr_pkg::ST_RDATA) begin
          nxt_shift  = regs.rdata;
          nxt_sda_oe = ~regs.rdata[7];
          nxt_ptr    = ptr_ff + 8'h01;
        end
      end else if (state_ff == alr_pkg::ST_RDATA) begin
        nxt_shift  = {shift_ff[6:0], 1'b0};
        nxt_sda_oe = ~shift_ff[6];
      end
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scl_q_ff   <= 1'b1;
      sda_q_ff   <= 1'b1;
      state_ff   <= alr_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      ptr_ff     <= 8'h00;
      sda_oe_ff  <= 1'b0;
    end else begin
      scl_q_ff   <= i_scl;
      sda_q_ff   <= i_sda;
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      ptr_ff     <= nxt_ptr;
      sda_oe_ff  <= nxt_sda_oe;
    end
  end

  assign o_sda_oe    = sda_oe_ff;
  assign regs.wr_stb = wr_pulse;
  assign regs.addr   = ptr_ff;
  assign regs.wdata  = shift_ff;

endmodule : alr_i2c_slave

// [verilog/alr_top.sv]
/*
  Ambient light readout: integration timer, gain-weighted saturating
  channel counters, paired result capture, window compare and interrupt,
  byte register file behind the serial slave.
  Assumes the analog front end gives one-cycle pulses per charge quantum
  on each channel, and that serial lines are synchronous to the clock.
*/
`timescale 1ns/1ps

module alr_top #(
  parameter int SHORT_CYC = alr_pkg::T_SHORT_CYC,
  parameter int LONG_CYC  = alr_pkg::T_LONG_CYC
) (
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_SRST,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output logic            O_SDA_OUT,
  output logic            O_SDA_OE,
  input  wire logic       I_VIS_PULSE,
  input  wire logic       I_IR_PULSE,
  output logic [1:0]      O_GAIN_SEL,
  output logic            O_MEAS_ACTIVE,
  output logic            O_INT_N
);

  localparam int CNT_W = $clog2(LONG_CYC + 1);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SHORT_CYC < 2 || LONG_CYC < SHORT_CYC) begin : g_bad_period
    $error("integration periods must be at least 2 and long >= short");
  end

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  alr_reg_if bus ();

  alr_i2c_slave u_slave (
    .i_clk    (I_CORE_CLK),
    .i_srst   (I_SRST),
    .i_scl    (I_SCL),
    .i_sda    (I_SDA),
    .o_sda_oe (O_SDA_OE),
    .regs     (bus.slave)
  );

  assign O_SDA_OUT = 1'b0;  // open drain: only ever pulls low

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0]       mode_ff, gain_ff;
  logic [15:0]      upper_ff, lower_ff;
  logic [15:0]      vis_res_ff, ir_res_ff;
  logic [15:0]      vis_acc_ff, ir_acc_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             int_flag_ff;

  wire wr_mode  = bus.wr_stb && bus.addr == alr_pkg::REG_MODE;
  wire wr_gain  = bus.wr_stb && bus.addr == alr_pkg::REG_GAIN;
  wire wr_up_lo = bus.wr_stb && bus.addr == alr_pkg::REG_UPPER_LO;
  wire wr_up_hi = bus.wr_stb && bus.addr == alr_pkg::REG_UPPER_HI;
  wire wr_lo_lo = bus.wr_stb && bus.addr == alr_pkg::REG_LOWER_LO;
  wire wr_lo_hi = bus.wr_stb && bus.addr == alr_pkg::REG_LOWER_HI;
  wire int_clr  = bus.wr_stb && bus.addr == alr_pkg::REG_STATUS
                  && bus.wdata[alr_pkg::STATUS_INT_BIT];

  // configuration bytes
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      mode_ff <= alr_pkg::MODE_RESET;
      gain_ff <= alr_pkg::GAIN_RESET;
    end else begin
      if (wr_mode) mode_ff <= bus.wdata;
      if (wr_gain) gain_ff <= bus.wdata;
    end
  end

  // window limits, written one byte at a time
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      upper_ff <= alr_pkg::UPPER_RESET;
      lower_ff <= alr_pkg::LOWER_RESET;
    end else begin
      if (wr_up_lo) upper_ff[7:0]  <= bus.wdata;
      if (wr_up_hi) upper_ff[15:8] <= bus.wdata;
      if (wr_lo_lo) lower_ff[7:0]  <= bus.wdata;
      if (wr_lo_hi) lower_ff[15:8] <= bus.wdata;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (bus.addr)
      alr_pkg::REG_MODE:     bus.rdata = mode_ff;
      alr_pkg::REG_GAIN:     bus.rdata = gain_ff;
      alr_pkg::REG_VIS_LO:   bus.rdata = vis_res_ff[7:0];
      alr_pkg::REG_VIS_HI:   bus.rdata = vis_res_ff[15:8];
      alr_pkg::REG_IR_LO:    bus.rdata = ir_res_ff[7:0];
      alr_pkg::REG_IR_HI:    bus.rdata = ir_res_ff[15:8];
      alr_pkg::REG_STATUS:   bus.rdata = {7'h00, int_flag_ff};
      alr_pkg::REG_UPPER_LO: bus.rdata = upper_ff[7:0];
      alr_pkg::REG_UPPER_HI: bus.rdata = upper_ff[15:8];
      alr_pkg::REG_LOWER_LO: bus.rdata = lower_ff[7:0];
      alr_pkg::REG_LOWER_HI: bus.rdata = lower_ff[15:8];
      default:               bus.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // integration and capture
  // ----------------------------------------------------------------
  wire              meas_en  = mode_ff[alr_pkg::MODE_MEAS_EN_BIT];
  wire              long_sel = mode_ff[alr_pkg::MODE_TIME_SEL_BIT];
  wire              int_en   = gain_ff[alr_pkg::GAIN_INT_EN_BIT];
  wire [1:0]        gain_sel = gain_ff[alr_pkg::GAIN_SEL_LSB +: 2];
  wire [7:0]        step     = alr_pkg::gain_step(gain_sel);  // same step both channels
  wire [CNT_W-1:0]  last_cnt = long_sel ? CNT_W'(LONG_CYC - 1)
                                        : CNT_W'(SHORT_CYC - 1);
  wire              period_end = meas_en && cnt_ff == last_cnt;
  wire [15:0]       vis_next = I_VIS_PULSE ? alr_pkg::sat_add(vis_acc_ff, step) : vis_acc_ff;
  wire [15:0]       ir_next  = I_IR_PULSE  ? alr_pkg::sat_add(ir_acc_ff, step)  : ir_acc_ff;
  wire              out_win  = vis_next < lower_ff || vis_next > upper_ff;

  // a mode write restarts the period so a shorter time never overruns
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !meas_en || wr_mode || period_end) cnt_ff <= '0;
    else                                            cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // counts grow by gain per quantum over the period
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !meas_en || wr_mode || period_end) begin
      vis_acc_ff <= 16'h0000;
      ir_acc_ff  <= 16'h0000;
    end else begin
      vis_acc_ff <= vis_next;  // saturates at full scale
      ir_acc_ff  <= ir_next;
    end
  end

  // both results land on the same edge
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      vis_res_ff <= 16'h0000;
      ir_res_ff  <= 16'h0000;
    end else if (period_end) begin
      vis_res_ff <= vis_next;
      ir_res_ff  <= ir_next;
    end
  end

  // sticky flag: a new event beats a clear in the same cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST)                           int_flag_ff <= 1'b0;
    else if (period_end && int_en && out_win) int_flag_ff <= 1'b1;
    else if (int_clr)                     int_flag_ff <= 1'b0;
  end

  assign O_INT_N       = ~int_flag_ff;
  assign O_GAIN_SEL    = gain_sel;
  assign O_MEAS_ACTIVE = meas_en;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  a_result_pair_edge: assert property (
    (!$stable(vis_res_ff) || !$stable(ir_res_ff)) |-> $past(period_end))
    else $error("result changed outside a period end");
  a_int_on_window: assert property (
    period_end && int_en && out_win |=> !O_INT_N)
    else $error("out of window result did not raise interrupt");
  a_int_cause: assert property (
    $fell(O_INT_N) |-> $past(period_end && int_en && out_win))
    else $error("interrupt raised without cause");
  a_int_clear_ok: assert property (
    int_clr && !(period_end && int_en && out_win) |=> O_INT_N)
    else $error("status clear ignored");
  // cycles since the last restart, counted apart from the period counter
  int since_ff;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !meas_en || wr_mode || period_end) since_ff <= 0;
    else                                            since_ff <= since_ff + 1;
  end

  a_period_length: assert property (
    meas_en && !wr_mode |->
      period_end == (since_ff == (long_sel ? LONG_CYC - 1 : SHORT_CYC - 1)))
    else $error("integration period wrong length");
  a_gain_step_vis: assert property (
    meas_en && !wr_mode && !period_end && I_VIS_PULSE && vis_acc_ff < 16'hff00
    |=> vis_acc_ff == $past(vis_acc_ff) + 16'($past(step)))
    else $error("visible count not stepped by gain");
  a_gain_shared: assert property (
    meas_en && !wr_mode && !period_end && I_IR_PULSE && ir_acc_ff < 16'hff00
    |=> ir_acc_ff - $past(ir_acc_ff) == 16'(alr_pkg::gain_step($past(O_GAIN_SEL))))
    else $error("infrared count not stepped by shared gain");
  a_count_ceiling: assert property (
    vis_acc_ff == 16'hffff && meas_en && !wr_mode && !period_end |=> vis_acc_ff == 16'hffff)
    else $error("visible count wrapped past full scale");
  a_limit_write: assert property (
    wr_lo_hi |=> lower_ff[15:8] == $past(bus.wdata))
    else $error("lower limit high byte not written");

  c_period_end:  cover property (period_end ##1 !$stable(vis_res_ff));
  c_int_raise:   cover property ($fell(O_INT_N));
  c_set_and_clr: cover property (int_clr && period_end && int_en && out_win);
  c_saturate:    cover property (vis_acc_ff == 16'hffff);

endmodule : alr_top

// [sim/alr_host.sv]
/*
  Two-wire bus master model standing in for the host controller.
  Assumes the bench resolves SDA with a pull-up and calls these tasks
  from one process only.
*/
`timescale 1ns/1ps
module alr_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // --------------------------------------------------------------
  // line control
  // --------------------------------------------------------------
  // bus idles released, so the pull-up shows high between frames
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // every change lands on a falling core edge, after a wait of 2, 3 or 5 clocks
  task automatic hw(input int n);
    repeat (n) @(negedge i_clk);
  endtask : hw

  // also serves as repeated start from a low clock
  task automatic start();
    o_sda_oe = 1'b0;
    hw(5);
    o_scl = 1'b1;
    hw(5);
    o_sda_oe = 1'b1;
    hw(5);
    o_scl = 1'b0;
    hw(2);
  endtask : start

  task automatic stop();
    o_sda_oe = 1'b1;
    hw(5);
    o_scl = 1'b1;
    hw(5);
    o_sda_oe = 1'b0;
    hw(5);
  endtask : stop

  // data held through the high phase, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    o_sda_oe = ~b;
    hw(5);
    o_scl = 1'b1;
    hw(3);
    r = i_sda;
    hw(3);
    o_scl = 1'b0;
    hw(2);
  endtask : bitx

  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, ack_n);
  endtask : wbyte

  // nack on the last byte ends the burst
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(last, r);
  endtask : rbyte
endmodule : alr_host

// [sim/test_ambient_light_readout.sv]
/*
  Self-checking bench for the light readout top with a bus master model.
  Assumes shortened periods of 3000 and 8000 core clocks.
*/
`timescale 1ns/1ps
module test_ambient_light_readout;
  localparam int SHORT = 3000;
  localparam int LONG  = 8000;
  logic        clk   = 1'b0;
  logic        srst  = 1'b1;
  logic        vis_p = 1'b0;
  logic        ir_p  = 1'b0;
  logic        scl, host_oe, dev_oe, sda, sda_out, meas, int_n;
  logic [1:0]  gsel;
  logic [31:0] seed  = 32'h1141;
  logic [7:0]  rb[$];
  int          rm[int];
  int          stp[4] = '{1, 2, 64, 128};
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // pull-up unless a side drives; the device's own level shows when it drives
  assign sda = host_oe ? 1'b0 : (dev_oe ? sda_out : 1'b1);
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  alr_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) alr_top_inst (
    .I_CORE_CLK(clk), .I_SRST(srst), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(dev_oe), .I_VIS_PULSE(vis_p), .I_IR_PULSE(ir_p),
    .O_GAIN_SEL(gsel), .O_MEAS_ACTIVE(meas), .O_INT_N(int_n));
  alr_host alr_host_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    logic k;
    alr_host_inst.start();
    alr_host_inst.wbyte({alr_pkg::SLAVE_ADDR, 1'b0}, k);
    chk(k, 0);
    alr_host_inst.wbyte(a, k);
    for (int i = 0; i < n; i++) alr_host_inst.wbyte(d[8*i+:8], k);
    alr_host_inst.stop();
  endtask : wr

  // pointer write, repeated start, burst read with auto-increment
  task automatic rdchk(input logic [7:0] a, input int n);
    logic       k;
    logic [7:0] b;
    rb.delete();
    alr_host_inst.start();
    alr_host_inst.wbyte({alr_pkg::SLAVE_ADDR, 1'b0}, k);
    alr_host_inst.wbyte(a, k);
    alr_host_inst.start();
    alr_host_inst.wbyte({alr_pkg::SLAVE_ADDR, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      alr_host_inst.rbyte(i == n - 1, b);
      rb.push_back(b);
      chk(b, rm[a+i][7:0]);
    end
    alr_host_inst.stop();
  endtask : rdchk

  // pulses start 200 clocks after the call, which follows the mode write's stop, well clear of the period's ends
  task automatic meas_run(input int nv, input int ni, input int g, output int t0);
    t0 = cyc;
    repeat (200) @(negedge clk);
    for (int i = 0; i < 600; i++) begin
      vis_p = (i < nv);
      ir_p  = (i < ni);
      @(negedge clk);
    end
    vis_p = 1'b0;
    ir_p  = 1'b0;
  endtask : meas_run

  task automatic waitto(input int t);
    while (cyc < t) @(negedge clk);
  endtask : waitto

  task automatic set_res(input int v, input int r);
    rm[8'h46] = v & 255;
    rm[8'h47] = v >> 8;
    rm[8'h48] = r & 255;
    rm[8'h49] = r >> 8;
  endtask : set_res

  // watchdog: a hang counts as a mismatch
  initial begin
    #1_500_000;
    n_fail++;
    close_out();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    int g, nv, ni, ev, ei, t0;
    logic k;
    for (int a = 8'h41; a <= 8'h50; a++) rm[a] = 0;
    rm[8'h4b] = 255;
    rm[8'h4c] = 255;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk(int_n, 1);
    chk(gsel, 0);
    chk(meas, 0);
    rdchk(8'h46, 9);
    rdchk(8'h41, 2);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h42, i, 1);
      rm[8'h42] = i;
      chk(gsel, i);
      rdchk(8'h42, 1);
    end
    $display("gain test done");
    // foreign address refused, unmapped place reads zero and drops writes
    alr_host_inst.start();
    alr_host_inst.wbyte({7'h3a, 1'b0}, k);
    chk(k, 1);
    alr_host_inst.stop();
    wr(8'h50, 16'h005a, 1);
    rdchk(8'h50, 1);
    $display("bus test done");
    // short period, visible result sits exactly on the upper limit
    g  = xs() % 4;
    nv = 1 + xs() % 200;
    ni = 1 + xs() % 200;
    ev = nv * stp[g];
    ei = ni * stp[g];
    wr(8'h42, 4 | g, 1);
    wr(8'h4b, ev, 2);
    rm[8'h42] = 4 | g;
    rm[8'h4b] = ev & 255;
    rm[8'h4c] = ev >> 8;
    rdchk(8'h4b, 4);
    wr(8'h41, 1, 1);
    chk(meas, 1);
    meas_run(nv, ni, g, t0);
    waitto(t0 + SHORT + 300);
    set_res(ev, ei);
    rdchk(8'h46, 4);
    // host side: each count divided by the shared gain gives the quanta seen
    chk(16'({rb[1], rb[0]} / stp[g]), 16'(nv));
    chk(16'({rb[3], rb[2]} / stp[g]), 16'(ni));
    chk(int_n, 1);
    $display("short period test done");
    // long period, top gain, visible saturates above the window
    ei = ni * 128;
    wr(8'h42, 16'h0007, 1);
    wr(8'h41, 3, 1);
    meas_run(600, ni, 3, t0);
    waitto(t0 + SHORT + 300);
    rdchk(8'h46, 4);
    waitto(t0 + LONG + 300);
    set_res(65535, ei);
    rdchk(8'h46, 4);
    chk(int_n, 0);
    rm[8'h4a] = 1;
    rdchk(8'h4a, 1);
    wr(8'h4a, 1, 1);
    rm[8'h4a] = 0;
    chk(int_n, 1);
    rdchk(8'h4a, 1);
    $display("long period test done");
    // lower limit above an empty period's count: result falls below the window
    wr(8'h4d, 16'h0100, 2);
    rm[8'h4d] = 0;
    rm[8'h4e] = 1;
    rdchk(8'h4d, 2);
    waitto(t0 + 2 * LONG + 300);
    set_res(0, 0);
    rdchk(8'h46, 4);
    chk(int_n, 0);
    $display("lower limit test done");
    close_out();
  end
endmodule : test_ambient_light_readout
